/* File: prx_host.sv */
// host side: byte writes and single-byte reads
module prx_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] wdata_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// write strobe stays up until the next read drops it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		{addr_o, wdata_o, wr_o, rd_o} <= {a, v, 2'h2};
	endtask
	// single-byte read: one-cycle strobe, data sampled just after the following edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		{addr_o, wr_o, rd_o} <= {a, 2'h1};
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule

/* File: prx_monitor.sv */
// watches the register port, the drive and gain fields and the reduced-drive output
module prx_monitor #(
	parameter logic [7:0] PART_ID = prx_pkg::PART_ID_DEFAULT
) (
	input wire logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, result_done_i,
	input wire logic irq_asserted_i, reduced_drive_bit_i, drive_reduced_o,
	input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire logic [1:0] led_drive_strength_o, measure_gain_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	ctrl_readback_a: assert property (reg_wr_i && reg_addr_i == 8'h0F ##1 reg_rd_i &&
		reg_addr_i == 8'h0F |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hFC)) else $error("ctrl");
	drive_field_a: assert property (reg_wr_i && reg_addr_i == 8'h0F
		|=> led_drive_strength_o == $past(reg_wdata_i[7:6])) else $error("drive");
	gain_field_a: assert property (reg_wr_i && reg_addr_i == 8'h0F
		|=> measure_gain_o == $past(reg_wdata_i[3:2])) else $error("gain");
	id_read_a: assert property (reg_rd_i && reg_addr_i == 8'h12
		|=> reg_rdata_o == PART_ID) else $error("id");
	irq_status_a: assert property (reg_rd_i && reg_addr_i == 8'h13
		|=> reg_rdata_o[5] == $past(irq_asserted_i)) else $error("irq");
	valid_status_a: assert property (result_done_i ##[1:4] reg_rd_i &&
		reg_addr_i == 8'h13 |=> reg_rdata_o[1]) else $error("valid");
	status_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h13
		|=> (reg_rdata_o & 8'h9D) == 8'h00) else $error("reserved");
	reduced_drive_a: assert property (drive_reduced_o == reduced_drive_bit_i)
		else $error("reduced");
endmodule
bind prx_regs prx_monitor #(.PART_ID(PART_ID)) u_mon (.*);

/* File: prx_pkg.sv */
package prx_pkg;
	// register offsets
	localparam logic [7:0] ADDR_ANALOG_CONTROL = 8'h0F;
	localparam logic [7:0] ADDR_PART_IDENTIFICATION = 8'h12;
	localparam logic [7:0] ADDR_MEASUREMENT_STATUS = 8'h13;
	localparam logic [7:0] ADDR_RESULT_LOW_BYTE = 8'h18;
	localparam logic [7:0] ADDR_RESULT_HIGH_BYTE = 8'h19;
	// control field positions
	localparam int DRIVE_LSB = 6;
	localparam int DIODE_LSB = 4;
	localparam int GAIN_LSB = 2;
	// status bit positions
	localparam int STAT_SAT_BIT = 6;
	localparam int STAT_IRQ_BIT = 5;
	localparam int STAT_VALID_BIT = 1;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h20;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	// arbitrary neutral identification value
	localparam logic [7:0] PART_ID_DEFAULT = 8'hA5;
	// legal diode code
	localparam logic [1:0] DIODE_CH1 = 2'h2;
	// gain codes
	typedef enum logic [1:0] {
		PRX_GAIN_1X = 2'h0,
		PRX_GAIN_2X = 2'h1,
		PRX_GAIN_4X = 2'h2,
		PRX_GAIN_8X = 2'h3
	} prx_gain_t;
endpackage

/* File: prx_regs.sv */
// What this block does
// [RQ1] analog control register at 0x0F, bits1:0 reserved
// [RQ2] bits 7:6 choose led drive strength
// [RQ3] bits 5:4 photodiode select, only 10 valid
// [RQ4] bits 3:2 choose measurement gain
// [RQ5] read-only identification register at 0x12
// [RQ6] read-only status register at 0x13
// [RQ7] status bit 6 shows saturation
// [RQ8] status bit 5 mirrors threshold interrupt
// [RQ9] status bit 1 marks completed integration
// [RQ10] 16-bit result at 0x18 low, 0x19 high
// [RQ11] low-byte read latches upper byte shadow
// [RQ12] shadow holds across later integrations
// [RQ13] host reads result as two-byte burst; prx_host does single-byte reads
// [RQ14] reduced drive bit cuts current ninefold
// [RQ15] interrupt on result outside threshold window; this block only mirrors irq_asserted_i
// [RQ16] reserved bits read zero, writes ignored
module prx_regs #(
	parameter logic [7:0] PART_ID = prx_pkg::PART_ID_DEFAULT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register access from the serial bus engine
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// measurement engine
	input wire logic result_done_i,
	input wire logic [15:0] result_i,
	input wire logic result_sat_i,
	input wire logic irq_asserted_i,
	input wire logic reduced_drive_bit_i,
	// analog front-end controls
	output logic [1:0] led_drive_strength_o,
	output logic [1:0] photodiode_select_o,
	output logic [1:0] measure_gain_o,
	output logic drive_reduced_o,
	output logic diode_code_bad_o
);
	logic [5:0] control_q; // bits 7:2, reserved bits not stored
	logic [15:0] result_q; // latest result
	logic sat_q; // saturation flag
	logic valid_q; // integration complete flag
	logic [7:0] rdata_q; // registered read data
	logic [7:0] shadow_hi; // latched upper byte
	logic [7:0] status_w; // assembled status
	logic [7:0] rdata_d;
	logic lo_read;

	// control register write; reserved bits 1:0 dropped
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			control_q <= prx_pkg::CONTROL_RESET[7:2];
		end else if (reg_wr_i && reg_addr_i == prx_pkg::ADDR_ANALOG_CONTROL) begin
			control_q <= reg_wdata_i[7:2]; // [RQ1] [RQ16]
		end
	end

	// result capture on each completed integration
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			result_q <= prx_pkg::RESULT_RESET;
			sat_q <= 1'b0;
		end else if (result_done_i) begin
			result_q <= result_i; // [RQ10]
			sat_q <= result_sat_i; // [RQ7]
		end
	end

	// valid is sticky once any integration finished; writes cannot clear it
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			valid_q <= 1'b0;
		end else if (result_done_i) begin
			valid_q <= 1'b1; // [RQ9] [RQ6]
		end
	end

	assign lo_read = reg_rd_i && reg_addr_i == prx_pkg::ADDR_RESULT_LOW_BYTE;

	// shadow loads the current upper byte; a result landing same cycle is not seen
	prx_shadow #(
		.WIDTH(8)
	) u_shadow (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.load_i(lo_read), // [RQ11]
		.data_i(result_q[15:8]),
		.data_o(shadow_hi)
	);

	// status assembly, reserved bits zero; the irq level comes from the threshold logic
	always_comb begin
		status_w = 8'h00; // [RQ16]
		status_w[prx_pkg::STAT_SAT_BIT] = sat_q; // [RQ7]
		status_w[prx_pkg::STAT_IRQ_BIT] = irq_asserted_i; // [RQ8] [RQ15]
		status_w[prx_pkg::STAT_VALID_BIT] = valid_q; // [RQ9]
	end

	// read decode; unmapped offsets return zero
	always_comb begin
		case (reg_addr_i)
			prx_pkg::ADDR_ANALOG_CONTROL: rdata_d = {control_q, 2'h0}; // [RQ16]
			prx_pkg::ADDR_PART_IDENTIFICATION: rdata_d = PART_ID; // [RQ5]
			prx_pkg::ADDR_MEASUREMENT_STATUS: rdata_d = status_w; // [RQ6]
			prx_pkg::ADDR_RESULT_LOW_BYTE: rdata_d = result_q[7:0]; // [RQ10]
			prx_pkg::ADDR_RESULT_HIGH_BYTE: rdata_d = shadow_hi; // [RQ12]
			default: rdata_d = 8'h00;
		endcase
	end

	// read data registered on the read strobe, held until the next read
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	// front-end fields
	assign led_drive_strength_o = control_q[prx_pkg::DRIVE_LSB-2 +: 2]; // [RQ2]
	assign photodiode_select_o = control_q[prx_pkg::DIODE_LSB-2 +: 2]; // [RQ3]
	assign measure_gain_o = control_q[prx_pkg::GAIN_LSB-2 +: 2]; // [RQ4]
	// analog divides current by nine when set
	assign drive_reduced_o = reduced_drive_bit_i; // [RQ14]
	// flags a reserved diode code written by the host
	assign diode_code_bad_o = control_q[prx_pkg::DIODE_LSB-2 +: 2] != prx_pkg::DIODE_CH1; // [RQ3]
endmodule

/* File: prx_regs_test.sv */
module prx_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, reset_n_i = 1'b0, result_done_i = 1'b0, result_sat_i = 1'b0;
	logic irq_asserted_i = 1'b0, reduced_drive_bit_i = 1'b0, reg_wr_i, reg_rd_i;
	logic [15:0] result_i = 16'h0000;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
	logic [1:0] led_drive_strength_o, photodiode_select_o, measure_gain_o;
	logic drive_reduced_o, diode_code_bad_o;
	int n_mismatch = 0, total_checks = 0;
	// written value, read-back, diode fault flag
	logic [16:0] rows [4] = '{{8'hFF, 8'hFC, 1'b1}, {8'h21, 8'h20, 1'b0},
		{8'h96, 8'h94, 1'b1}, {8'h4B, 8'h48, 1'b1}};
	prx_regs i_dut (.*);
	prx_host i_host (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
		.wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
	initial forever #4 clk_i = ~clk_i;
	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one finished integration from the measurement side
	task automatic meas(input logic [15:0] r, input logic s);
		@(posedge clk_i);
		{result_i, result_sat_i, result_done_i} <= {r, s, 1'b1};
		@(posedge clk_i);
		result_done_i <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		i_host.rd(a, d);
		cmp({d, 1'b0}, {e, 1'b0});
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk(8'h0F, 8'h20);
		foreach (rows[i]) begin
			i_host.wr(8'h0F, rows[i][16:9]);
			i_host.rd(8'h0F, d);
			cmp({d, diode_code_bad_o}, rows[i][8:0]);
			cmp({3'h0, led_drive_strength_o, photodiode_select_o, measure_gain_o},
				{3'h0, rows[i][16:11]});
		end
		i_host.wr(8'h12, 8'h00);
		chk(8'h12, prx_pkg::PART_ID_DEFAULT);
		@(posedge clk_i);
		{irq_asserted_i, reduced_drive_bit_i} <= 2'h3;
		meas(16'h1234, 1'b1);
		i_host.wr(8'h13, 8'hFF);
		chk(8'h13, 8'h62);
		cmp({8'h00, drive_reduced_o}, 9'h001);
		chk(8'h18, 8'h34);
		meas(16'hABCD, 1'b0);
		chk(8'h19, 8'h12);
		chk(8'h18, 8'hCD);
		chk(8'h19, 8'hAB);
		chk(8'h00, 8'h00);
		// second reset in mid-run: sat and valid flags, shadow and control go back; irq status bit stays set
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		chk(8'h0F, 8'h20);
		chk(8'h13, 8'h20);
		chk(8'h19, 8'h00);
		tally_and_finish();
	end
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule

/* File: prx_shadow.sv */
// holding register for the upper result byte
module prx_shadow #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// capture
	input wire logic load_i,
	input wire logic [WIDTH-1:0] data_i,
	// held value
	output logic [WIDTH-1:0] data_o
);
	logic [WIDTH-1:0] held_q;

	// captured only on low-byte reads, so new results cannot tear the pair
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			held_q <= '0;
		end else if (load_i) begin
			held_q <= data_i; // [RQ11]
		end
	end

	assign data_o = held_q; // [RQ12]
endmodule
